/* pkg/tp_ctl_pkg.sv */
// Constants and register map for the twisted-pair link, polarity and collision block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM slave port with waitrequest.
package tp_ctl_pkg;
  // Clock and bit timing
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned BIT_TIME_NS     = 100;
  localparam int unsigned BIT_CYCLES      = (BIT_TIME_NS * CLK_MHZ) / 1000;
  // Clash hold, 1.5 bit times, rounded down
  localparam int unsigned CLASH_HOLD_NS   = 150;
  localparam int unsigned CLASH_CYCLES    = (CLASH_HOLD_NS * CLK_MHZ) / 1000;
  // Collision tail, 2 bit times
  localparam int unsigned COL_TAIL_BITS   = 2;
  localparam int unsigned COL_TAIL_CYCLES = COL_TAIL_BITS * BIT_CYCLES;
  // Link pulse counts
  localparam int unsigned LINK_PULSES     = 5;
  // Link loss time and beat period, in microseconds
  localparam int unsigned LINK_LOSS_US    = 100000;
  localparam int unsigned BEAT_PERIOD_US  = 16000;
  localparam int unsigned LINK_LOSS_CYC   = LINK_LOSS_US * CLK_MHZ;
  localparam int unsigned BEAT_CYC        = BEAT_PERIOD_US * CLK_MHZ;
  // Register byte offsets
  localparam logic [3:0] MODE_OFFSET      = 4'h0;
  localparam logic [3:0] STATUS_OFFSET    = 4'h4;
  localparam logic [3:0] TXERR_OFFSET     = 4'h8;
  // Mode register fields
  localparam int unsigned MODE_PORT_BIT   = 0;
  localparam int unsigned MODE_LRT_BIT    = 9;
  localparam int unsigned MODE_DLNK_BIT   = 12;
  localparam logic [15:0] MODE_RESET      = 16'h0001;
  // Status register fields
  localparam int unsigned ST_LINK_BIT     = 0;
  localparam int unsigned ST_POL_BIT      = 1;
  localparam int unsigned ST_XMT_BIT      = 2;
  localparam int unsigned ST_RCV_BIT      = 3;
  localparam int unsigned ST_COL_BIT      = 4;
  localparam int unsigned ST_LOCK_BIT     = 5;
  localparam int unsigned ST_CLASH_BIT    = 6;
  // Transmit descriptor word carrier-lost bit
  localparam int unsigned CARRIER_LOST_ERROR_BIT        = 11;
  // Link states
  typedef enum logic [0:0] {
    LINK_FAIL = 1'b0,
    LINK_PASS = 1'b1
  } link_state_t;
  // Polarity correction states
  typedef enum logic [1:0] {
    POL_ARMED = 2'b00,
    POL_FIRST = 2'b01,
    POL_LOCK  = 2'b10
  } pol_state_t;
endpackage : tp_ctl_pkg

/* src/tp_link_polarity_collision_ctl.sv */
// Link integrity, receive polarity, collision and carrier-loss control for a 10 Mb/s port.
// Assumes pulse and packet qualifiers come from the analog front end, synchronous to clock.
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Clash input raises the internal clash signal, held 1.5 bit times after.
// - Clock recovery needs bits 1010, locks on second zero's mid-cell fall; left to the analog codec, not in this block.
// - Each Manchester bit sampled at a quarter bit time; done in the analog codec, not in this block.
// - AUI port: missing or dropped loopback carrier sets carrier-lost bit 11 afterwards.
// - Mode bit 9 picks standard or low receive thresholds.
// - Link beats sent on twisted pair while transmit idle, whatever the link-check disable.
// - Link checking on: no beats and no data means Link Fail.
// - Link Fail blocks tx, rx, loopback, collision until data or over 5 pulses.
// - Link-good status and LED off in Link Fail, on when link works.
// - Hardware reset forces Link Fail; software reset leaves state alone.
// - Link checking off keeps driver, receiver, loopback, collision enabled.
// - Polarity detection armed after reset or Link Fail, from beats and delimiters.
// - Link Fail accepts either beat polarity; leaves after 6 same-polarity beats.
// - Entering Link Pass sets polarity from last 5 beats; only those accepted after.
// - Correction stays armed until two consecutive same-polarity delimiter packets.
// - First delimiter packet sets polarity; confirming second locks, else latest wins.
// - Invalid delimiter packets never alter polarity.
// - Locked polarity stays locked until Link Fail or hardware reset.
// - Reversed-wiring flag follows inverted polarity; readable and sent to an LED.
// - Link Fail with link checking on keeps transmit, receive and collision flags inactive.
// - Changing from AUI to twisted pair forces Link Fail.
// - Rx and tx both active raise collision; holds 2 bit times after one idles.
module tp_link_polarity_collision_ctl #(
  parameter int unsigned LINK_LOSS = tp_ctl_pkg::LINK_LOSS_CYC,
  parameter int unsigned BEAT_GAP  = tp_ctl_pkg::BEAT_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Software reset strobe, no effect on link state
  input  wire logic        soft_reset,
  // Twisted-pair receive qualifiers and local transmit request
  input  wire logic        link_pulse,
  input  wire logic        link_pulse_neg,
  input  wire logic        rx_data_active,
  input  wire logic        packet_end,
  input  wire logic        end_delimiter_ok,
  input  wire logic        end_delimiter_neg,
  input  wire logic        tx_request,
  // Attachment-unit side
  input  wire logic        clash_input_pair,
  input  wire logic        aui_rx_pair,
  // Status and control outputs
  output logic             link_led_output,
  output logic             reversed_wiring_flag,
  output logic             tx_active_flag,
  output logic             rx_active_flag,
  output logic             col_active_flag,
  output logic             internal_clash_signal,
  output logic             tx_beat_pulse,
  output logic             tp_enable,
  output logic             low_rx_threshold_sel
);
  import tp_ctl_pkg::*;
  localparam int unsigned CW = 32;
  logic [15:0]   mode_control_reg;
  link_state_t   link_state;
  pol_state_t    pol_state;
  logic          link_good_status;
  logic [2:0]    beat_count;
  logic          beat_pol;
  logic [CW-1:0] loss_count;
  logic [CW-1:0] beat_timer;
  logic [3:0]    clash_count;
  logic [4:0]    clash_quiet;
  logic [4:0]    col_count;
  logic          rx_inverted;
  logic          carrier_lost_error;
  logic          aui_tx_seen_crs;
  logic          aui_crs_dropped;
  logic          tx_prev;
  logic          port_prev;
  logic          func_enable;
  logic          tp_selected;
  logic          link_check_disable;
  logic          beat_ok;
  logic          beat_is_neg;
  logic          force_fail;

  // Saturating counter step used by several timers
  function automatic logic [CW-1:0] dec_sat(input logic [CW-1:0] v);
    return (v == '0) ? '0 : v - 32'h0000_0001;
  endfunction : dec_sat

  assign tp_selected        = mode_control_reg[MODE_PORT_BIT];
  assign link_check_disable = mode_control_reg[MODE_DLNK_BIT];
  assign beat_is_neg        = link_pulse_neg ^ rx_inverted;
  // After Link Pass only the learned polarity counts
  assign beat_ok = link_pulse && (link_state == LINK_FAIL || !beat_is_neg);
  // Port change from AUI to twisted pair
  assign force_fail = tp_selected && !port_prev;
  assign func_enable = tp_selected && (link_check_disable || link_state == LINK_PASS);

  // Avalon slave: single wait cycle, then answer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(waitrequest && (read || write)) ;
    end
  end

  // Register writes taken at the edge where waitrequest is low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_control_reg <= MODE_RESET;
    end else if (write && !waitrequest && address == MODE_OFFSET) begin
      if (byteenable[0]) mode_control_reg[7:0]  <= writedata[7:0];
      if (byteenable[1]) mode_control_reg[15:8] <= writedata[15:8];
    end
  end

  // Read mux, unmapped reads return zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      case (address)
        MODE_OFFSET:   readdata <= {16'h0000, mode_control_reg};
        STATUS_OFFSET: readdata <= {25'h000_0000, internal_clash_signal,
                                    pol_state == POL_LOCK, col_active_flag,
                                    rx_active_flag, tx_active_flag,
                                    rx_inverted, link_good_status};
        // Carrier-lost bit at descriptor bit position
        TXERR_OFFSET:  readdata <= {20'h0_0000, carrier_lost_error, 11'h000};
        default:       readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Registered copies: port history, wiring flag and threshold select
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_prev            <= 1'b0;
      reversed_wiring_flag <= 1'b0;
      low_rx_threshold_sel <= 1'b0;
    end else begin
      // Port history for the AUI-to-twisted-pair change
      port_prev            <= tp_selected;
      reversed_wiring_flag <= rx_inverted;
      // Threshold select drives the analog receiver
      low_rx_threshold_sel <= mode_control_reg[MODE_LRT_BIT];
    end
  end

  // Link integrity machine; soft_reset deliberately unused here
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_state <= LINK_FAIL;
      beat_count <= 3'h0;
      beat_pol   <= 1'b0;
      loss_count <= '0;
    end else if (force_fail) begin
      link_state <= LINK_FAIL;
      beat_count <= 3'h0;
    end else begin
      case (link_state)
        LINK_FAIL: begin
          if (link_pulse) begin
            beat_pol   <= beat_is_neg;
            beat_count <= (beat_count != 3'h0 && beat_pol != beat_is_neg) ? 3'h1
                        : beat_count + 3'h1;
          end
          // Data or over 5 pulses leave Link Fail
          if (rx_data_active || (link_pulse && beat_count >= 3'(LINK_PULSES)
                                 && beat_pol == beat_is_neg)) begin
            link_state <= LINK_PASS;
            loss_count <= LINK_LOSS;
          end
        end
        LINK_PASS: begin
          beat_count <= 3'h0;
          // Silence for the loss time drops the link
          if (beat_ok || rx_data_active) begin
            loss_count <= LINK_LOSS;
          end else if (!link_check_disable && loss_count == '0) begin
            link_state <= LINK_FAIL;
          end else begin
            loss_count <= dec_sat(loss_count);
          end
        end
        default: link_state <= LINK_FAIL;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_good_status <= 1'b0;
      link_led_output  <= 1'b0;
    end else begin
      link_good_status <= link_state == LINK_PASS;
      link_led_output  <= link_state == LINK_PASS;
    end
  end

  // Polarity detection, re-armed on Link Fail
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pol_state   <= POL_ARMED;
      rx_inverted <= 1'b0;
    end else if (link_state == LINK_FAIL) begin
      pol_state <= POL_ARMED;
      // Polarity of the beats that pass the link
      if (link_pulse && beat_count >= 3'(LINK_PULSES) && beat_pol == beat_is_neg)
        rx_inverted <= rx_inverted ^ beat_is_neg;
    end else if (packet_end && end_delimiter_ok) begin
      case (pol_state)
        POL_ARMED: begin
          rx_inverted <= end_delimiter_neg;  // Raw polarity is the inversion itself
          pol_state   <= POL_FIRST;
        end
        POL_FIRST: begin
          if (end_delimiter_neg != rx_inverted) rx_inverted <= end_delimiter_neg;
          else                                  pol_state   <= POL_LOCK;
        end
        // Locked until Link Fail or reset
        POL_LOCK: pol_state <= POL_LOCK;
        default:  pol_state <= POL_ARMED;
      endcase
    end
  end

  // Activity flags gated by link function
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_active_flag <= 1'b0;
      rx_active_flag <= 1'b0;
      tp_enable      <= 1'b0;
    end else begin
      tx_active_flag <= func_enable && tx_request;
      rx_active_flag <= func_enable && rx_data_active;
      tp_enable      <= func_enable;
    end
  end

  // Collision while both active, 2-bit tail
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      col_active_flag <= 1'b0;
      col_count       <= 5'h00;
    end else if (!func_enable) begin
      col_active_flag <= 1'b0;
      col_count       <= 5'h00;
    end else if (tx_request && rx_data_active) begin
      col_active_flag <= 1'b1;
      col_count       <= 5'(COL_TAIL_CYCLES);
    end else if (col_count != 5'h00) begin
      col_count <= col_count - 5'h01;
    end else begin
      col_active_flag <= 1'b0;
    end
  end

  // Clash hold after the last cycle the clash input is high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clash_quiet           <= 5'h1f;
      clash_count           <= 4'h0;
      internal_clash_signal <= 1'b0;
    end else begin
      if (clash_input_pair)           clash_quiet <= 5'h00;
      else if (clash_quiet != 5'h1f) clash_quiet <= clash_quiet + 5'h01;
      if (clash_input_pair) begin
        internal_clash_signal <= 1'b1;
        clash_count           <= 4'(CLASH_CYCLES);
      end else if (clash_count != 4'h0) begin
        clash_count <= clash_count - 4'h1;
      end else begin
        internal_clash_signal <= 1'b0;
      end
    end
  end

  // Beat pulses while twisted pair selected and transmit idle, regardless of disable bit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      beat_timer    <= '0;
      tx_beat_pulse <= 1'b0;
    end else begin
      tx_beat_pulse <= 1'b0;
      if (tx_request || !tp_selected) begin
        beat_timer <= BEAT_GAP;
      end else if (beat_timer == '0) begin
        beat_timer    <= BEAT_GAP;
        tx_beat_pulse <= 1'b1;
      end else begin
        beat_timer <= dec_sat(beat_timer);
      end
    end
  end

  // AUI loopback carrier check over one transmission
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_prev            <= 1'b0;
      aui_tx_seen_crs    <= 1'b0;
      aui_crs_dropped    <= 1'b0;
      carrier_lost_error <= 1'b0;
    end else begin
      tx_prev <= tx_request;
      if (tx_request && !tx_prev) begin
        aui_tx_seen_crs <= aui_rx_pair;
        aui_crs_dropped <= 1'b0;
      end else if (tx_request) begin
        if (aui_rx_pair) aui_tx_seen_crs <= 1'b1;
        else if (aui_tx_seen_crs) aui_crs_dropped <= 1'b1;
      end
      // Set beats a same-cycle clear by write
      if (!tx_request && tx_prev && !tp_selected && (!aui_tx_seen_crs || aui_crs_dropped))
        carrier_lost_error <= 1'b1;
      else if (write && !waitrequest && address == TXERR_OFFSET && writedata[CARRIER_LOST_ERROR_BIT])
        carrier_lost_error <= 1'b0;
    end
  end

  // Recovery and decoding sit in the analog codec; 100 ns bit.
  // Assertions
  link_fail_flags_a: assert property (@(posedge clock) disable iff (!rstn)
    (link_state == LINK_FAIL && !link_check_disable) |=> !tx_active_flag && !rx_active_flag)
    else $error("activity flag set in Link Fail");
  port_change_a: assert property (@(posedge clock) disable iff (!rstn)
    force_fail |=> link_state == LINK_FAIL)
    else $error("port change did not force Link Fail");
  link_led_a: assert property (@(posedge clock) disable iff (!rstn)
    ##1 link_led_output == ($past(link_state) == LINK_PASS))
    else $error("link LED mismatch");
  pol_flag_a: assert property (@(posedge clock) disable iff (!rstn)
    ##1 reversed_wiring_flag == $past(rx_inverted))
    else $error("reversed wiring flag wrong");
  clash_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    (clash_quiet <= 5'(CLASH_CYCLES)) |-> internal_clash_signal)
    else $error("clash released early");
  col_tail_a: assert property (@(posedge clock) disable iff (!rstn)
    (func_enable && tx_request && rx_data_active) ##1 !(tx_request && rx_data_active)
      && func_enable |-> col_active_flag)
    else $error("collision tail missing");
  lock_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    (pol_state == POL_LOCK && link_state == LINK_PASS && !force_fail) |=>
      pol_state == POL_LOCK || $past(link_state) != link_state)
    else $error("polarity lock lost");
  invalid_etd_a: assert property (@(posedge clock) disable iff (!rstn)
    (link_state == LINK_PASS && !(packet_end && end_delimiter_ok) && !force_fail)
      |=> $stable(rx_inverted))
    else $error("polarity changed without valid delimiter");
endmodule : tp_link_polarity_collision_ctl

/* tb/tp_medium_model.sv */
// Behavioural model of the twisted-pair medium and of an external attachment unit.
// Assumes the bench calls its tasks; every output changes by NBA just after a rising edge.
`timescale 1ns/1ps
module tp_medium_model (
  // Clock, local transmit request and loopback mode
  input  wire logic       clock,
  input  wire logic       tx_request,
  input  wire logic [1:0] loop_mode,
  // Medium qualifiers
  output logic            link_pulse,
  output logic            link_pulse_neg,
  output logic            rx_data_active,
  output logic            packet_end,
  output logic            end_delimiter_ok,
  output logic            end_delimiter_neg,
  output logic            clash_input_pair,
  output logic            aui_rx_pair
);
  logic [7:0] loop_age;
  initial begin
    {link_pulse, rx_data_active, packet_end, clash_input_pair, aui_rx_pair} = 5'h00;
    {link_pulse_neg, end_delimiter_ok, end_delimiter_neg} = 3'h0;
    loop_age = 8'h00;
  end
  // Loopback: 0 never answers, 1 echoes, 2 drops early to mimic a faulty unit
  always @(posedge clock) begin
    loop_age <= tx_request ? loop_age + 8'h01 : 8'h00;
    aui_rx_pair <= tx_request && (loop_mode == 2'h1 || (loop_mode == 2'h2 && loop_age < 8'h03));
  end
  // One beat; a released line shows the inverse so no stale value passes
  task automatic beat(input logic neg);
    @(posedge clock);
    link_pulse <= 1'b1;
    link_pulse_neg <= neg;
    @(posedge clock);
    link_pulse <= 1'b0;
    link_pulse_neg <= ~neg;
  endtask : beat
  // One frame ending with a delimiter report
  task automatic packet(input logic ok, input logic neg, input int len);
    @(posedge clock);
    rx_data_active <= 1'b1;
    repeat (len) @(posedge clock);
    packet_end <= 1'b1;
    end_delimiter_ok <= ok;
    end_delimiter_neg <= neg;
    @(posedge clock);
    rx_data_active <= 1'b0;
    packet_end <= 1'b0;
    end_delimiter_ok <= ~ok;
    end_delimiter_neg <= ~neg;
  endtask : packet
  // Collision signal from the attachment unit
  task automatic clash(input int len);
    @(posedge clock);
    clash_input_pair <= 1'b1;
    repeat (len) @(posedge clock);
    clash_input_pair <= 1'b0;
  endtask : clash
endmodule : tp_medium_model

/* tb/tp_link_polarity_collision_ctl_tb.sv */
// Self-checking bench for the link, polarity and collision control block.
// Assumes tp_medium_model as the far side and shortened link-loss and beat counts.
`timescale 1ns/1ps
module tp_link_polarity_collision_ctl_tb;
  import tp_ctl_pkg::*;
  // Bus, control and medium signals
  logic        clock, rstn, read, write, waitrequest, soft_reset, tx_request;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic [1:0]  loop_mode;
  logic        link_pulse, link_pulse_neg, rx_data_active, packet_end;
  logic        end_delimiter_ok, end_delimiter_neg, clash_input_pair, aui_rx_pair;
  logic        link_led_output, reversed_wiring_flag, tx_active_flag, rx_active_flag;
  logic        col_active_flag, internal_clash_signal, tx_beat_pulse, tp_enable;
  logic        low_rx_threshold_sel;
  int          failures, total_checks, n, seed;
  logic [2:0]  lost_exp = 3'b101;
  logic [3:0]  pk [5] = '{4'h8, 4'h4, 4'he, 4'hf, 4'hb};

  tp_link_polarity_collision_ctl #(.LINK_LOSS(200), .BEAT_GAP(50)) DUT (
    .clock, .rstn, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .soft_reset, .link_pulse, .link_pulse_neg, .rx_data_active,
    .packet_end, .end_delimiter_ok, .end_delimiter_neg, .tx_request, .clash_input_pair,
    .aui_rx_pair, .link_led_output, .reversed_wiring_flag, .tx_active_flag,
    .rx_active_flag, .col_active_flag, .internal_clash_signal, .tx_beat_pulse,
    .tp_enable, .low_rx_threshold_sel);
  tp_medium_model med (.clock, .tx_request, .loop_mode, .link_pulse, .link_pulse_neg,
    .rx_data_active, .packet_end, .end_delimiter_ok, .end_delimiter_neg,
    .clash_input_pair, .aui_rx_pair);

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // Settle just after the edge so registered outputs have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc

  // Avalon access held until waitrequest is seen low; a hang ends the run
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    // Upper lanes and the ignored soft reset take random values
    byteenable <= {2'($urandom), 2'b11};
    soft_reset <= 1'($urandom);
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clock);
      w++;
    end while (waitrequest !== 1'b0 && w < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (w >= 20) begin
      failures++;
      summarize();
    end
  endtask : bus

  function automatic logic [31:0] stat_exp(input logic lnk, input logic inv, input logic lck);
    stat_exp = 32'h0000_0000;
    stat_exp[ST_LINK_BIT] = lnk;
    stat_exp[ST_POL_BIT] = inv;
    stat_exp[ST_LOCK_BIT] = lck;
  endfunction : stat_exp

  function automatic logic [31:0] mode_exp(input logic tp, input logic lr, input logic dl);
    mode_exp = 32'h0000_0000;
    mode_exp[MODE_PORT_BIT] = tp;
    mode_exp[MODE_LRT_BIT] = lr;
    mode_exp[MODE_DLNK_BIT] = dl;
  endfunction : mode_exp

  // Status word plus the LED and wiring outputs that mirror it
  task automatic stat(input logic lnk, input logic inv, input logic lck);
    bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
    check("status", q, stat_exp(lnk, inv, lck));
    check("link led", link_led_output, lnk);
    check("wiring flag", reversed_wiring_flag, inv);
  endtask : stat

  task automatic count_beats(input int k);
    n = 0;
    repeat (k) begin
      cyc(1);
      if (tx_beat_pulse === 1'b1) n++;
    end
  endtask : count_beats

  initial begin
    seed = $urandom(32'h0000_f8c2);
    {rstn, read, write, soft_reset, tx_request} = 5'h00;
    address = 4'h0;
    writedata = 32'h0000_0000;
    byteenable = 4'hf;
    loop_mode = 2'h0;
    failures = 0;
    total_checks = 0;
    cyc(16);
    rstn <= 1'b1;
    bus(1'b0, MODE_OFFSET, 32'h0000_0000);
    check("mode reset", q, {16'h0000, MODE_RESET});
    bus(1'b0, 4'hc, 32'h0000_0000);
    check("unmapped", q, 32'h0000_0000);
    stat(1'b0, 1'b0, 1'b0);
    count_beats(120);
    check("idle beats", n >= 2, 1);
    repeat (5) begin
      med.beat(1'b1);
      cyc(5 + $urandom % 20);
    end
    stat(1'b0, 1'b0, 1'b0);
    med.beat(1'b1);
    cyc(3);
    stat(1'b1, 1'b1, 1'b0);
    check("tp enable", tp_enable, 1);
    foreach (pk[i]) begin
      med.packet(pk[i][3], pk[i][2], 4 + $urandom % 16);
      cyc(2);
      stat(1'b1, pk[i][1], pk[i][0]);
    end
    tx_request <= 1'b1;
    cyc(3);
    check("tx flag", tx_active_flag, 1);
    med.packet(1'b0, 1'b0, 10);
    #1;
    check("col overlap", col_active_flag, 1);
    check("rx flag", rx_active_flag, 1);
    cyc(16);
    check("col tail", col_active_flag, 1);
    tx_request <= 1'b0;
    cyc(7);
    check("col end", col_active_flag, 0);
    soft_reset <= 1'b1;
    cyc(1);
    soft_reset <= 1'b0;
    stat(1'b1, 1'b1, 1'b1);
    repeat (7) begin
      med.beat(1'b0);
      cyc(28);
    end
    bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
    check("link lost", q[ST_LINK_BIT], 0);
    check("lock cleared", q[ST_LOCK_BIT], 0);
    tx_request <= 1'b1;
    cyc(3);
    check("tx flag fail", tx_active_flag, 0);
    check("tp enable fail", tp_enable, 0);
    tx_request <= 1'b0;
    // data ends Link Fail, polarity re-armed
    med.packet(1'b1, 1'b0, 8);
    cyc(2);
    stat(1'b1, 1'b0, 1'b0);
    bus(1'b1, MODE_OFFSET, mode_exp(1'b1, 1'b0, 1'b1));
    count_beats(260);
    check("beats kept", n >= 4, 1);
    check("link kept", link_led_output, 1);
    tx_request <= 1'b1;
    med.packet(1'b0, 1'b0, 6);
    #1;
    check("col kept", col_active_flag, 1);
    tx_request <= 1'b0;
    cyc(30);
    // loopback table on the attachment port
    bus(1'b1, MODE_OFFSET, mode_exp(1'b0, 1'b0, 1'b1));
    for (int i = 0; i < 3; i++) begin
      loop_mode <= i[1:0];
      tx_request <= 1'b1;
      cyc(6 + $urandom % 25);
      tx_request <= 1'b0;
      cyc(4);
      bus(1'b0, TXERR_OFFSET, 32'h0000_0000);
      check("carrier lost", q[CARRIER_LOST_ERROR_BIT], lost_exp[i]);
      bus(1'b1, TXERR_OFFSET, 32'h0000_0800);
    end
    med.clash(6);
    #1;
    check("clash on", internal_clash_signal, 1);
    cyc(14);
    check("clash hold", internal_clash_signal, 1);
    cyc(5);
    check("clash off", internal_clash_signal, 0);
    bus(1'b1, MODE_OFFSET, mode_exp(1'b1, 1'b0, 1'b1));
    cyc(2);
    check("port switch", link_led_output, 0);
    bus(1'b1, MODE_OFFSET, mode_exp(1'b1, 1'b1, 1'b0));
    cyc(2);
    check("low thr on", low_rx_threshold_sel, 1);
    bus(1'b0, MODE_OFFSET, 32'h0000_0000);
    check("mode back", q, mode_exp(1'b1, 1'b1, 1'b0));
    bus(1'b1, MODE_OFFSET, mode_exp(1'b1, 1'b0, 1'b0));
    cyc(2);
    check("low thr off", low_rx_threshold_sel, 0);
    med.packet(1'b1, 1'b1, 5);
    cyc(2);
    check("link up", link_led_output, 1);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(1);
    stat(1'b0, 1'b0, 1'b0);
    summarize();
  end
endmodule : tp_link_polarity_collision_ctl_tb
